// ==== tls_defs.vh ====
// Operation
// (R01) While the sequencer is enabled, regulation mode writes are refused.
// (R02) Input shutoff by turn-on threshold or current limit aborts the sequence.
// (R03) Repeating sub-mode alternates low and high endlessly without any trigger.
// (R04) Repeating cycle: rise, top dwell, fall, bottom dwell.
// (R05) Six settings plus a sub-mode selector for repeating, pulse or toggle.
// (R06) Pulse and toggle start at the low level when the input switches on.
// (R07) Pulse sub-mode holds the low level while no trigger arrives.
// (R08) Pulse trigger: rise, top dwell, then fall back to low.
// (R09) Pulse sub-mode ignores the bottom dwell setting.
// (R10) Pulse triggers count only at the low level; others are discarded.
// (R11) Triggers come from pin, key pair, bus GET, common and subsystem commands.
// (R12) Toggle sub-mode holds the low level until the first trigger.
// (R13) Each toggle trigger flips the target using rise or fall ramp, then holds.
// (R14) Toggle sub-mode ignores both dwell settings.
// (R15) Dwells span 0 to 655.35 ms, ramps 10 us upward, 10 us steps; the code holds each dwell one step longer than its setting.
// (R16) Sequencer runs only in current, voltage or resistance mode, not power.
// (R17) Software disables the step list before enabling this sequencer.
// (R18) External trigger source uses TTL levels; falling edge triggers.
// (R19) Ramps move linearly and arrive exactly when the duration expires.
`ifndef TLS_DEFS_VH
`define TLS_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TLS_OFS_CTRL 8'h00
`define TLS_OFS_BOT_SET 8'h04
`define TLS_OFS_TOP_SET 8'h08
`define TLS_OFS_BOT_DWELL 8'h0C
`define TLS_OFS_TOP_DWELL 8'h10
`define TLS_OFS_RISE 8'h14
`define TLS_OFS_FALL 8'h18
`define TLS_OFS_EXTERNAL_TRIGGER_PIN 8'h1C
`define TLS_OFS_STATUS 8'h20

// ----------------------------------------
// Field positions and encodings
// ----------------------------------------
`define TLS_CTRL_EN 0
`define TLS_CTRL_SUB_LO 1
`define TLS_CTRL_SUB_HI 2
`define TLS_CTRL_MODE_LO 4
`define TLS_CTRL_MODE_HI 5
`define TLS_EXTERNAL_TRIGGER_PIN_COMMON 0
`define TLS_EXTERNAL_TRIGGER_PIN_SUBSYS 1
`define TLS_SUB_REPEAT 2'h0
`define TLS_SUB_PULSE 2'h1
`define TLS_SUB_TOGGLE 2'h2
`define TLS_MODE_CC 2'h0
`define TLS_MODE_CV 2'h1
`define TLS_MODE_CR 2'h2
`define TLS_MODE_CP 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TLS_RST_LEVEL 16'h0000
`define TLS_RST_DWELL 16'h0000
`define TLS_RST_RAMP 16'h0001

// ----------------------------------------
// Timing
// ----------------------------------------
`define TLS_CLK_NS 40
`define TLS_STEP_NS 10000
`define TLS_STEP_CYC (`TLS_STEP_NS / `TLS_CLK_NS)

`endif

// ==== tls_sequencer.v ====
`timescale 1ns/100ps
`include "tls_defs.vh"

module tls_sequencer (
  input wire mclk, // System clock, 25 MHz.
  input wire rst, // Synchronous reset, active high.
  input wire [7:0] addr, // Register byte address.
  input wire [31:0] wdata, // Register write data.
  input wire wr, // Write strobe.
  input wire rd, // Read strobe.
  output reg [31:0] rdata, // Read data, valid the cycle after rd.
  input wire input_on, // Load input is switched on.
  input wire von_shutoff, // Input shut off by turn-on threshold.
  input wire ilimit_shutoff, // Input shut off by current limit.
  input wire external_trigger_pin, // External trigger, falling edge active.
  input wire key_trigger, // Front key pair trigger pulse.
  input wire get_trigger, // Bus group execute trigger pulse.
  output reg [15:0] setpoint, // Setpoint to the regulation loop.
  output reg seq_active, // Sequencer is driving the setpoint.
  output reg [1:0] active_mode // Regulation mode in force.
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_LOW = 3'h1;
  localparam ST_RISE = 3'h2;
  localparam ST_HIGH = 3'h3;
  localparam ST_FALL = 3'h4;

  // The step count is worked out wide and cut to the divider width on purpose.
  localparam [31:0] STEP_WIDE = `TLS_STEP_CYC;
  localparam [8:0] STEP_CYC = STEP_WIDE[8:0];

  reg enable_reg;
  reg [1:0] submode_reg;
  reg [1:0] mode_reg;
  reg [15:0] bottom_setpoint_reg;
  reg [15:0] top_setpoint_reg;
  reg [15:0] bottom_dwell_reg;
  reg [15:0] top_dwell_reg;
  reg [15:0] ramp_up_duration_reg;
  reg [15:0] ramp_down_duration_reg;
  reg bus_external_trigger_pin_reg;
  reg abort_reg;
  reg pin_prev_reg;
  reg [8:0] div_reg;
  reg tick;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] elapsed_reg;
  reg [15:0] elapsed_next;
  reg [15:0] setpoint_next;
  reg [15:0] ramp_dur;
  reg [15:0] ramp_from;
  reg [15:0] ramp_to;
  reg [31:0] ramp_prod;
  reg [31:0] ramp_quot;
  reg [15:0] ramp_val;
  reg [15:0] ramp_pos;
  wire trigger;
  wire run;
  wire shutoff;
  wire [15:0] elapsed_inc;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Settings load from the bus; the mode field is frozen while enabled.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      enable_reg <= 1'b0;
      submode_reg <= `TLS_SUB_REPEAT;
      mode_reg <= `TLS_MODE_CC;
      bottom_setpoint_reg <= `TLS_RST_LEVEL;
      top_setpoint_reg <= `TLS_RST_LEVEL;
      bottom_dwell_reg <= `TLS_RST_DWELL;
      top_dwell_reg <= `TLS_RST_DWELL;
      ramp_up_duration_reg <= `TLS_RST_RAMP;
      ramp_down_duration_reg <= `TLS_RST_RAMP;
    end
    else if (wr)
    begin
      case (addr)
        `TLS_OFS_CTRL:
        begin
          // Enable is refused while the power mode is selected. [R16]
          enable_reg <= wdata[`TLS_CTRL_EN] &
            ((enable_reg ? mode_reg : wdata[`TLS_CTRL_MODE_HI:`TLS_CTRL_MODE_LO])
            != `TLS_MODE_CP);
          submode_reg <= wdata[`TLS_CTRL_SUB_HI:`TLS_CTRL_SUB_LO]; // [R05]
          if (!enable_reg)
            mode_reg <= wdata[`TLS_CTRL_MODE_HI:`TLS_CTRL_MODE_LO]; // [R01]
        end
        `TLS_OFS_BOT_SET: bottom_setpoint_reg <= wdata[15:0];
        `TLS_OFS_TOP_SET: top_setpoint_reg <= wdata[15:0];
        `TLS_OFS_BOT_DWELL: bottom_dwell_reg <= wdata[15:0]; // [R15]
        `TLS_OFS_TOP_DWELL: top_dwell_reg <= wdata[15:0]; // [R15]
        // A zero ramp is raised to the one-step minimum. [R15]
        `TLS_OFS_RISE: ramp_up_duration_reg <= (wdata[15:0] == 16'h0000) ?
          16'h0001 : wdata[15:0];
        `TLS_OFS_FALL: ramp_down_duration_reg <= (wdata[15:0] == 16'h0000) ?
          16'h0001 : wdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Read data are registered and stand for one cycle; unmapped reads give zero.
  always @(posedge mclk)
  begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      case (addr)
        `TLS_OFS_CTRL: rdata <= {26'h0000000, mode_reg, 1'b0, submode_reg, enable_reg};
        `TLS_OFS_BOT_SET: rdata <= {16'h0000, bottom_setpoint_reg};
        `TLS_OFS_TOP_SET: rdata <= {16'h0000, top_setpoint_reg};
        `TLS_OFS_BOT_DWELL: rdata <= {16'h0000, bottom_dwell_reg};
        `TLS_OFS_TOP_DWELL: rdata <= {16'h0000, top_dwell_reg};
        `TLS_OFS_RISE: rdata <= {16'h0000, ramp_up_duration_reg};
        `TLS_OFS_FALL: rdata <= {16'h0000, ramp_down_duration_reg};
        `TLS_OFS_STATUS: rdata <= {11'h000, abort_reg, seq_active, state_reg, setpoint};
        default: rdata <= 32'h00000000;
      endcase
    end
    else
      rdata <= 32'h00000000;
  end

  // ----------------------------------------
  // Trigger sources
  // ----------------------------------------
  // Command triggers written to the trigger register become one-cycle pulses.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      bus_external_trigger_pin_reg <= 1'b0;
      pin_prev_reg <= 1'b1;
    end
    else
    begin
      bus_external_trigger_pin_reg <= wr & (addr == `TLS_OFS_EXTERNAL_TRIGGER_PIN) &
        (wdata[`TLS_EXTERNAL_TRIGGER_PIN_COMMON] | wdata[`TLS_EXTERNAL_TRIGGER_PIN_SUBSYS]);
      pin_prev_reg <= external_trigger_pin;
    end
  end

  // All sources merge into one trigger; the pin counts on its falling edge.
  assign trigger = (pin_prev_reg & ~external_trigger_pin) | // [R18]
    key_trigger | get_trigger | bus_external_trigger_pin_reg; // [R11]

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // One enable pulse per 10 us step.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      div_reg <= 9'h000;
      tick <= 1'b0;
    end
    else if (div_reg == STEP_CYC - 9'h001)
    begin
      div_reg <= 9'h000;
      tick <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 9'h001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Abort latch
  // ----------------------------------------
  // A shutoff stops the sequence until software disables and re-enables it.
  assign shutoff = von_shutoff | ilimit_shutoff;
  always @(posedge mclk)
  begin
    if (rst)
      abort_reg <= 1'b0;
    else if (shutoff & enable_reg)
      abort_reg <= 1'b1; // [R02]
    else if (!enable_reg)
      abort_reg <= 1'b0;
  end

  assign run = enable_reg & input_on & ~abort_reg & ~shutoff &
    (mode_reg != `TLS_MODE_CP); // [R16]
  assign elapsed_inc = elapsed_reg + 16'h0001;

  // ----------------------------------------
  // Linear ramp
  // ----------------------------------------
  // The level moves by the step fraction elapsed over duration. [R19]
  // On a tick the step being entered is used, so every step stands one full tick, except the first step of a ramp started by a trigger.
  always @*
  begin
    ramp_pos = tick ? elapsed_inc : elapsed_reg;
    ramp_dur = (state_reg == ST_FALL) ? ramp_down_duration_reg : ramp_up_duration_reg;
    ramp_from = (state_reg == ST_FALL) ? top_setpoint_reg : bottom_setpoint_reg;
    ramp_to = (state_reg == ST_FALL) ? bottom_setpoint_reg : top_setpoint_reg;
    if (ramp_to >= ramp_from)
      ramp_prod = (ramp_to - ramp_from) * ramp_pos;
    else
      ramp_prod = (ramp_from - ramp_to) * ramp_pos;
    ramp_quot = ramp_prod / {16'h0000, ramp_dur};
    if (ramp_to >= ramp_from)
      ramp_val = ramp_from + ramp_quot[15:0];
    else
      ramp_val = ramp_from - ramp_quot[15:0];
  end

  // ----------------------------------------
  // Sequencer state machine
  // ----------------------------------------
  // Next state, step count and setpoint for each sub-mode.
  always @*
  begin
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    setpoint_next = setpoint;
    if (!run)
    begin
      state_next = ST_IDLE;
      elapsed_next = 16'h0000;
      setpoint_next = bottom_setpoint_reg;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // Every sub-mode starts from the low level. [R06]
          state_next = ST_LOW;
          elapsed_next = 16'h0000;
          setpoint_next = bottom_setpoint_reg;
        end
        ST_LOW:
        begin
          setpoint_next = bottom_setpoint_reg;
          if (submode_reg == `TLS_SUB_REPEAT)
          begin
            // Free-running: the bottom dwell expires with no trigger. [R03]
            if (tick)
            begin
              if (elapsed_reg >= bottom_dwell_reg)
              begin
                state_next = ST_RISE; // [R04]
                elapsed_next = 16'h0000;
              end
              else
                elapsed_next = elapsed_inc;
            end
          end
          else if (trigger)
          begin
            // Pulse and toggle leave the low level only on a trigger. [R07] [R09]
            state_next = ST_RISE; // [R10] [R12] [R14]
            elapsed_next = 16'h0000;
          end
        end
        ST_RISE:
        begin
          setpoint_next = ramp_val;
          if (tick)
          begin
            if (elapsed_inc >= ramp_dur)
            begin
              state_next = ST_HIGH; // [R04] [R08]
              elapsed_next = 16'h0000;
              setpoint_next = top_setpoint_reg; // [R19]
            end
            else
              elapsed_next = elapsed_inc;
          end
        end
        ST_HIGH:
        begin
          setpoint_next = top_setpoint_reg;
          if (submode_reg == `TLS_SUB_TOGGLE)
          begin
            // Top level is held until the next trigger. [R13] [R14]
            if (trigger)
            begin
              state_next = ST_FALL;
              elapsed_next = 16'h0000;
            end
          end
          else if (tick)
          begin
            if (elapsed_reg >= top_dwell_reg)
            begin
              state_next = ST_FALL; // [R04] [R08]
              elapsed_next = 16'h0000;
            end
            else
              elapsed_next = elapsed_inc;
          end
        end
        ST_FALL:
        begin
          setpoint_next = ramp_val;
          if (tick)
          begin
            if (elapsed_inc >= ramp_dur)
            begin
              state_next = ST_LOW; // [R04] [R08] [R13]
              elapsed_next = 16'h0000;
              setpoint_next = bottom_setpoint_reg; // [R19]
            end
            else
              elapsed_next = elapsed_inc;
          end
        end
        default:
        begin
          state_next = ST_IDLE;
          elapsed_next = 16'h0000;
        end
      endcase
    end
  end

  // State, counter and output registers.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      elapsed_reg <= 16'h0000;
      setpoint <= `TLS_RST_LEVEL;
      seq_active <= 1'b0;
      active_mode <= `TLS_MODE_CC;
    end
    else
    begin
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
      setpoint <= setpoint_next;
      seq_active <= run;
      active_mode <= mode_reg;
    end
  end

endmodule

// ==== tls_seq_sva.sv ====
`timescale 1ns/100ps
// ----
// Port checker
// ----
module tls_seq_sva (
  input wire mclk, // Clock.
  input wire rst, // Reset.
  input wire [7:0] addr, // Address.
  input wire [31:0] wdata, // Data in.
  input wire wr, // Write.
  input wire rd, // Read.
  input wire [31:0] rdata, // Data out.
  input wire input_on, // Input on.
  input wire von_shutoff, // Trip.
  input wire ilimit_shutoff, // Trip.
  input wire external_trigger_pin, // Pin.
  input wire key_trigger, // Key.
  input wire get_trigger, // Bus.
  input wire [15:0] setpoint, // Level.
  input wire seq_active, // Running.
  input wire [1:0] active_mode // Mode.
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Relations between the controls and the level output.
  chk_mode_locked: assert property (seq_active && $past(seq_active) |-> $stable(active_mode))
    else $error("mode moved while running");
  chk_trip_stops: assert property (von_shutoff || ilimit_shutoff |-> ##[1:2] !seq_active)
    else $error("trip did not stop run");
  chk_off_stops: assert property (!input_on |-> ##[1:2] !seq_active)
    else $error("run without input");
  chk_power_idle: assert property (active_mode == 2'h3 |-> !seq_active)
    else $error("run in power mode");
  chk_start_cond: assert property ($rose(seq_active) |-> $past(input_on) && active_mode != 2'h3)
    else $error("bad start");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("stray read data");
  chk_status_read: assert property (rd && addr == 8'h20 |=> rdata[15:0] == $past(setpoint) && rdata[19] == $past(seq_active))
    else $error("status mismatch");
  chk_ramp_steady: assert property (seq_active && !wr && $changed(setpoint) |=> $stable(setpoint) || !seq_active)
    else $error("level moved off tick");
  // Main scenarios.
  cov_start: cover property ($rose(seq_active));
  cov_trip: cover property (ilimit_shutoff && seq_active);
  cov_key: cover property (key_trigger && seq_active);
endmodule

bind tls_sequencer tls_seq_sva u_sva (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .input_on,
  .von_shutoff, .ilimit_shutoff, .external_trigger_pin, .key_trigger, .get_trigger, .setpoint,
  .seq_active, .active_mode);

// ==== tls_src_model.sv ====
`timescale 1ns/100ps
// ----
// Source under test and trigger pin
// ----
module tls_src_model (
  input wire mclk, // Clock.
  output reg external_trigger_pin, // TTL line, idles high.
  output reg ilimit_shutoff, // Limit trip.
  output reg von_shutoff // Threshold trip.
);
  // The line rests high, so only a falling edge can count.
  initial
  begin
    external_trigger_pin = 1'b1;
    ilimit_shutoff = 1'b0;
    von_shutoff = 1'b0;
  end
  // Pulls the line low for a prompt or slow width.
  task fire(input int n);
    begin
      @(posedge mclk);
      external_trigger_pin <= 1'b0;
      repeat (n) @(posedge mclk);
      external_trigger_pin <= 1'b1;
    end
  endtask
  // Sags below the threshold or hits the limit for a while.
  task trip(input bit lim, input int n);
    begin
      @(posedge mclk);
      ilimit_shutoff <= lim;
      von_shutoff <= !lim;
      repeat (n) @(posedge mclk);
      ilimit_shutoff <= 1'b0;
      von_shutoff <= 1'b0;
    end
  endtask
endmodule

// ==== tls_sequencer_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
// ----
// Testbench
// ----
module tls_sequencer_tb;
  reg mclk, rst, wr, rd, input_on, key_trigger, get_trigger;
  reg [7:0] addr;
  reg [31:0] wdata, v;
  wire [31:0] rdata;
  wire [15:0] setpoint;
  wire seq_active, external_trigger_pin, von_shutoff, ilimit_shutoff;
  wire [1:0] active_mode;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int d;

  tls_sequencer dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .input_on, .von_shutoff,
    .ilimit_shutoff, .external_trigger_pin, .key_trigger, .get_trigger, .setpoint, .seq_active,
    .active_mode);
  tls_src_model src (.mclk, .external_trigger_pin, .ilimit_shutoff, .von_shutoff);

  // Clock and cycle count.
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // Verdict.
  task end_sim;
    begin
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Register bus cycles.
  task wr_reg(input [7:0] a, input [31:0] x);
    begin
      @(posedge mclk);
      wr <= 1;
      addr <= a;
      wdata <= x;
      @(posedge mclk);
      wr <= 0;
    end
  endtask
  task rd_reg(input [7:0] a, output [31:0] q);
    begin
      @(posedge mclk);
      rd <= 1;
      addr <= a;
      @(posedge mclk);
      rd <= 0;
      #1 q = rdata;
    end
  endtask
  // Waits for the next level change; checks value and, if dl is set, the wait.
  task nxt(input [15:0] e, input int dl);
    int t0;
    reg [15:0] s;
    begin
      #1;
      t0 = cyc;
      s = setpoint;
      while (setpoint === s && cyc - t0 < 3000)
      begin
        @(posedge mclk);
        #1;
      end
      d = cyc - t0;
      if (d >= 3000)
      begin
        error_cnt++;
        $display("Error span limit expected change seen none");
      end
      `CHK("setpoint", e, setpoint)
      if (dl >= 0)
        `CHK("span", dl, d)
    end
  endtask
  task pulse_line(input bit k);
    begin
      @(posedge mclk);
      if (k) key_trigger <= 1; else get_trigger <= 1;
      @(posedge mclk);
      key_trigger <= 0;
      get_trigger <= 0;
    end
  endtask

  // Hang guard.
  initial
  begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    $display("Error watchdog expired");
    end_sim;
  end

  // Main sequence.
  initial
  begin
    {rst, wr, rd, input_on, key_trigger, get_trigger} = 6'h20;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (4) @(posedge mclk);
    rst <= 0;
    rd_reg(8'h14, v); `CHK("rise", 32'h1, v)
    rd_reg(8'h24, v); `CHK("hole", 32'h0, v)
    wr_reg(8'h04, 32'h1000); wr_reg(8'h08, 32'h2000);
    wr_reg(8'h14, 32'h0); rd_reg(8'h14, v); `CHK("rise min", 32'h1, v)
    wr_reg(8'h14, 32'h2); wr_reg(8'h18, 32'h1); wr_reg(8'h0C, 32'h1);
    // Single pulse; a slow pin trigger mid-pulse must be dropped.
    wr_reg(8'h00, 32'h3);
    input_on <= 1;
    repeat (600) @(posedge mclk);
    #1 `CHK("low", 16'h1000, setpoint)
    rd_reg(8'h20, v); `CHK("state", 3'h1, v[18:16])
    src.fire(3);
    nxt(16'h1800, -1);
    fork
      src.fire(40);
    join_none
    nxt(16'h2000, 250);
    nxt(16'h1000, 500);
    repeat (1000) @(posedge mclk);
    #1 `CHK("one pulse", 16'h1000, setpoint)
    pulse_line(1);
    nxt(16'h1800, -1); nxt(16'h2000, 250); nxt(16'h1000, 500);
    // Toggle with common and subsystem register commands and the bus GET source.
    wr_reg(8'h00, 32'h0); wr_reg(8'h00, 32'h5);
    repeat (300) @(posedge mclk);
    #1 `CHK("wait", 16'h1000, setpoint)
    wr_reg(8'h1C, 32'h1);
    nxt(16'h1800, -1); nxt(16'h2000, 250);
    repeat (1000) @(posedge mclk);
    #1 `CHK("held", 16'h2000, setpoint)
    wr_reg(8'h00, 32'h25); rd_reg(8'h00, v); `CHK("ctrl", 32'h5, v)
    `CHK("mode", 2'h0, active_mode)
    pulse_line(0);
    nxt(16'h1000, -1);
    wr_reg(8'h1C, 32'h2);
    nxt(16'h1800, -1);
    // Repeating waveform; the list sequencer is never run here.
    wr_reg(8'h00, 32'h0);
    repeat (5) @(posedge mclk);
    wr_reg(8'h00, 32'h1);
    nxt(16'h1800, -1); nxt(16'h2000, 250);
    nxt(16'h1000, 500); nxt(16'h1800, 750);
    // Limit trip aborts and stays aborted.
    src.trip(1, 20);
    rd_reg(8'h20, v); `CHK("abort", 2'h2, v[20:19])
    `CHK("rest", 16'h1000, setpoint)
    wr_reg(8'h00, 32'h0); wr_reg(8'h00, 32'h1);
    src.trip(0, 5);
    #1 `CHK("von", 1'b0, seq_active)
    // Voltage mode is taken while disabled and then runs.
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h00, 32'h11);
    rd_reg(8'h00, v);
    `CHK("cv mode", 2'h1, active_mode)
    `CHK("cv run", 1'b1, seq_active)
    // Power mode refuses the enable.
    wr_reg(8'h00, 32'h0); wr_reg(8'h00, 32'h30); wr_reg(8'h00, 32'h31);
    rd_reg(8'h00, v); `CHK("ctrl cp", 32'h30, v)
    `CHK("cp idle", 1'b0, seq_active)
    // A reset in mid-run returns the outputs and settings to their reset values.
    wr_reg(8'h00, 32'h1);
    @(posedge mclk);
    rst <= 1;
    repeat (4) @(posedge mclk);
    rst <= 0;
    #1 `CHK("rst level", 16'h0000, setpoint)
    `CHK("rst idle", 1'b0, seq_active)
    rd_reg(8'h00, v);
    `CHK("rst ctrl", 32'h0, v)
    rd_reg(8'h04, v);
    `CHK("rst bottom", 32'h0, v)
    end_sim;
  end
endmodule
